// ---- dmi_pkg.sv ----
// Purpose: shared types and constants for the mask/inversion byte lanes
// Assumes: two byte lanes, one beat per rising link clock edge
// Notes: thresholds are counts of one bits within a byte
package dmi_pkg;

    localparam int LANES = 2;
    localparam int BYTE_W = 8;
    localparam int DQ_W = 16;
    localparam int TRAIN_DEPTH = 8;
    localparam int TRAIN_PTR_W = 3;
    localparam int MASK_LSB = 2;
    localparam logic [3:0] RD_INV_OVER = 4'h4;
    localparam logic [3:0] MASK_MIN_ONES = 4'h5;
    localparam logic [TRAIN_PTR_W-1:0] PTR_RST = 3'h0;
    localparam logic [1:0] SYNC_RST = 2'h3;

    // kind of an incoming write beat
    typedef enum logic [1:0] {
        DMI_WR,
        DMI_MWR,
        DMI_WFIFO
    } dmi_wkind_e;

    // kind of an outgoing read beat
    typedef enum logic {
        DMI_RD,
        DMI_RFIFO
    } dmi_rkind_e;

    // mode bits: dm_dis is mask-off, wr_inv/rd_inv enable inversion
    typedef struct packed {
        logic dm_dis;
        logic wr_inv;
        logic rd_inv;
    } dmi_cfg_s;

    typedef struct packed {
        logic valid;
        dmi_wkind_e kind;
        logic [DQ_W-1:0] dq;
        logic [LANES-1:0] dmi;
    } dmi_wbeat_s;

    typedef struct packed {
        logic valid;
        dmi_rkind_e kind;
        logic [DQ_W-1:0] data;
    } dmi_rreq_s;

    typedef struct packed {
        logic valid;
        logic [DQ_W-1:0] data;
        logic [LANES-1:0] en;
    } dmi_arrw_s;

    typedef struct packed {
        logic [DQ_W-1:0] dq;
        logic [LANES-1:0] dmi;
    } dmi_tentry_s;

    localparam dmi_arrw_s ARRW_RST = '0;

    function automatic logic [3:0] dmi_ones(input logic [BYTE_W-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < BYTE_W; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : dmi_ones

endpackage : dmi_pkg

// ---- dmi_lane.sv ----
// Purpose: per-byte mask and inversion decisions, write and read
// Assumes: inputs already sampled in the link domain
// Notes: purely combinational, one instance per byte lane
`timescale 1ns/1ps
module dmi_lane
    import dmi_pkg::*;
(
    // mode
    input wire dmi_cfg_s cfg_i,
    // write beat
    input wire dmi_wkind_e wkind_i,
    input wire logic [BYTE_W-1:0] wdq_i,
    input wire logic wdmi_i,
    output logic [BYTE_W-1:0] wdata_o,
    output logic wen_o,
    output logic willegal_o,
    // read beat
    input wire logic [BYTE_W-1:0] rdata_i,
    output logic [BYTE_W-1:0] rdq_o,
    output logic rflag_o
);

    logic mask_hit;

    // only the upper six bits vote, so the flag bit pattern stays legal
    assign mask_hit = dmi_ones({wdq_i[BYTE_W-1:MASK_LSB], 2'h0})
        >= MASK_MIN_ONES;

    always_comb begin
        wdata_o = wdq_i;
        wen_o = 1'b0;
        willegal_o = 1'b0;
        unique case (wkind_i)
            DMI_WR: begin
                wen_o = 1'b1;
                if (cfg_i.wr_inv && wdmi_i) begin
                    wdata_o = ~wdq_i;
                end
            end
            DMI_MWR: begin
                if (cfg_i.dm_dis) begin
                    willegal_o = 1'b1;
                end else if (!cfg_i.wr_inv) begin
                    wen_o = !wdmi_i;
                end else begin
                    wen_o = wdmi_i || !mask_hit;
                    if (wdmi_i) begin
                        wdata_o = ~wdq_i;
                    end
                end
            end
            DMI_WFIFO: begin
                wen_o = 1'b0;
            end
            default: begin
                wen_o = 1'b0;
            end
        endcase
    end

    always_comb begin
        rflag_o = cfg_i.rd_inv && (dmi_ones(rdata_i) > RD_INV_OVER);
        rdq_o = rflag_o ? ~rdata_i : rdata_i;
    end

endmodule : dmi_lane

// ---- dmi_mask_inv_top.sv ----
// Purpose: mask/inversion pin handling for both byte lanes
// Assumes: write beats and read data arrive on the link clock
// Notes: mode bits live on the core clock and cross in as levels
// What this block does
// - all functions off: ignore pin, no drive
// - write inversion flips bytes flagged high
// - read inversion when more than four ones
// - mask only: high pin masks its byte
// - inversion plus mask: low pin, five ones in bits 7:2 masks
// - masked-write beats with a high pin are inversion patterns; low-pin beats under five ones are written as sent
// - write-fifo training stores pin, no mask/inversion
// - read-fifo training returns stored pin pattern
// - mask on when bit low; write inversion bit
// - never change command spacing; training wins
// - read inversion follows its mode bit
// - pin sampled with its lane's data
`timescale 1ns/1ps
module dmi_mask_inv_top
    import dmi_pkg::*;
(
    // core clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // mode bits, core domain
    input wire logic dm_disable_i,
    input wire logic wr_inv_en_i,
    input wire logic rd_inv_en_i,
    output logic illegal_cmd_o,
    // link clock
    input wire logic lk_clk_i,
    // link beats
    input wire dmi_wbeat_s wbeat_i,
    input wire dmi_rreq_s rreq_i,
    // array write port
    output dmi_arrw_s arr_wr_o,
    // pin side
    output logic dmi_rx_en_o,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic [LANES-1:0] dmi_o,
    output logic [LANES-1:0] dmi_oe_n_o
);

    typedef struct packed {
        logic rst_m;
        logic rst_q;
        dmi_cfg_s cfg_m;
        dmi_cfg_s cfg_q;
        logic ill_tgl;
        dmi_arrw_s arr;
        logic [DQ_W-1:0] dq_out;
        logic dq_oe_n;
        logic [LANES-1:0] dmi_out;
        logic [LANES-1:0] dmi_oe_n;
        logic [TRAIN_PTR_W-1:0] wptr;
        logic [TRAIN_PTR_W-1:0] rptr;
        dmi_tentry_s [TRAIN_DEPTH-1:0] fifo;
    } dmi_lstate_s;

    typedef struct packed {
        logic ill_m;
        logic ill_q;
        logic ill_p;
        logic ill_pulse;
    } dmi_cstate_s;

    dmi_lstate_s lk_ff;
    dmi_lstate_s nxt_lk;
    dmi_cstate_s core_ff;
    dmi_cstate_s nxt_core;

    dmi_cfg_s cfg_raw;
    logic any_en;
    logic [LANES-1:0] rx_dmi;
    logic [DQ_W-1:0] w_data;
    logic [LANES-1:0] w_en;
    logic [LANES-1:0] w_ill;
    logic [DQ_W-1:0] r_dq;
    logic [LANES-1:0] r_flag;

    // mask is enabled when its mode bit reads zero
    assign cfg_raw = '{dm_dis: dm_disable_i,
                       wr_inv: wr_inv_en_i,
                       rd_inv: rd_inv_en_i};
    assign any_en = !lk_ff.cfg_q.dm_dis || lk_ff.cfg_q.wr_inv
        || lk_ff.cfg_q.rd_inv;
    // receiver off means the pin reads as a constant low
    assign rx_dmi = any_en ? wbeat_i.dmi : '0;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            dmi_lane u_lane (
                .cfg_i(lk_ff.cfg_q),
                .wkind_i(wbeat_i.kind),
                .wdq_i(wbeat_i.dq[g*BYTE_W +: BYTE_W]),
                .wdmi_i(rx_dmi[g]),
                .wdata_o(w_data[g*BYTE_W +: BYTE_W]),
                .wen_o(w_en[g]),
                .willegal_o(w_ill[g]),
                .rdata_i(rreq_i.data[g*BYTE_W +: BYTE_W]),
                .rdq_o(r_dq[g*BYTE_W +: BYTE_W]),
                .rflag_o(r_flag[g])
            );
        end
    endgenerate

    // link domain: no stall path, every beat is answered next edge
    always_comb begin
        nxt_lk = lk_ff;
        nxt_lk.rst_m = rst_i;
        nxt_lk.rst_q = lk_ff.rst_m;
        nxt_lk.cfg_m = cfg_raw;
        nxt_lk.cfg_q = lk_ff.cfg_m;
        nxt_lk.arr = ARRW_RST;
        nxt_lk.dq_out = '0;
        nxt_lk.dq_oe_n = 1'b1;
        nxt_lk.dmi_out = '0;
        nxt_lk.dmi_oe_n = '1;
        if (wbeat_i.valid) begin
            if (wbeat_i.kind == DMI_WFIFO) begin
                nxt_lk.fifo[lk_ff.wptr] = '{dq: wbeat_i.dq, dmi: rx_dmi};
                nxt_lk.wptr = lk_ff.wptr + 3'h1;
            end else if (|w_ill) begin
                nxt_lk.ill_tgl = !lk_ff.ill_tgl;
            end else begin
                nxt_lk.arr = '{valid: 1'b1, data: w_data, en: w_en};
            end
        end
        if (rreq_i.valid) begin
            nxt_lk.dq_oe_n = 1'b0;
            if (rreq_i.kind == DMI_RFIFO) begin
                nxt_lk.dq_out = lk_ff.fifo[lk_ff.rptr].dq;
                nxt_lk.dmi_out = lk_ff.fifo[lk_ff.rptr].dmi;
                nxt_lk.dmi_oe_n = {LANES{!any_en}};
                nxt_lk.rptr = lk_ff.rptr + 3'h1;
            end else begin
                nxt_lk.dq_out = r_dq;
                nxt_lk.dmi_out = r_flag;
                nxt_lk.dmi_oe_n = {LANES{!lk_ff.cfg_q.rd_inv}};
            end
        end
        if (lk_ff.rst_q) begin
            nxt_lk.ill_tgl = 1'b0;
            nxt_lk.arr = ARRW_RST;
            nxt_lk.dq_out = '0;
            nxt_lk.dq_oe_n = 1'b1;
            nxt_lk.dmi_out = '0;
            nxt_lk.dmi_oe_n = '1;
            nxt_lk.wptr = PTR_RST;
            nxt_lk.rptr = PTR_RST;
            nxt_lk.fifo = '0;
        end
    end

    always_ff @(posedge lk_clk_i) begin
        lk_ff <= nxt_lk;
    end

    // core domain: toggle sync, edge taken from second and third stage
    always_comb begin
        nxt_core.ill_m = lk_ff.ill_tgl;
        nxt_core.ill_q = core_ff.ill_m;
        nxt_core.ill_p = core_ff.ill_q;
        nxt_core.ill_pulse = core_ff.ill_q ^ core_ff.ill_p;
        if (rst_i) begin
            nxt_core = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        core_ff <= nxt_core;
    end

    assign illegal_cmd_o = core_ff.ill_pulse;
    assign arr_wr_o = lk_ff.arr;
    assign dq_o = lk_ff.dq_out;
    assign dq_oe_n_o = lk_ff.dq_oe_n;
    assign dmi_o = lk_ff.dmi_out;
    assign dmi_oe_n_o = lk_ff.dmi_oe_n;
    assign dmi_rx_en_o = any_en;

    // checks in the link domain
    sequence s_wbeat(dmi_wkind_e k);
        wbeat_i.valid && wbeat_i.kind == k;
    endsequence

    sequence s_mwr_live;
        s_wbeat(DMI_MWR) and (!lk_ff.cfg_q.dm_dis);
    endsequence

    a_off_no_drive: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        rreq_i.valid && !any_en |=> dmi_oe_n_o == '1 && !dmi_rx_en_o)
        else $error("pin driven with all functions off");

    a_illegal_drop: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_wbeat(DMI_MWR) and lk_ff.cfg_q.dm_dis |=> !arr_wr_o.valid)
        else $error("illegal masked write reached the array");

    a_write_invert: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_wbeat(DMI_WR) and (lk_ff.cfg_q.wr_inv && wbeat_i.dmi[0])
        |=> arr_wr_o.data[7:0] == ~$past(wbeat_i.dq[7:0]))
        else $error("flagged write byte not inverted");

    a_read_invert: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        rreq_i.valid && rreq_i.kind == DMI_RD && lk_ff.cfg_q.rd_inv
        && dmi_ones(rreq_i.data[15:8]) > RD_INV_OVER
        |=> dmi_o[1] && dq_o[15:8] == ~$past(rreq_i.data[15:8]))
        else $error("heavy read byte not inverted");

    a_plain_write: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_wbeat(DMI_WR) |=> arr_wr_o.valid && arr_wr_o.en == '1)
        else $error("plain write was masked");

    a_dm_mask: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_mwr_live and (!lk_ff.cfg_q.wr_inv)
        |=> arr_wr_o.en == ~$past(wbeat_i.dmi))
        else $error("mask enables do not follow the pin");

    a_dbi_mask: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_mwr_live and (lk_ff.cfg_q.wr_inv && !wbeat_i.dmi[0]
        && dmi_ones({wbeat_i.dq[7:2], 2'h0}) >= MASK_MIN_ONES)
        |=> !arr_wr_o.en[0])
        else $error("five-ones pattern not masked");

    a_dbi_keep: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_mwr_live and (lk_ff.cfg_q.wr_inv && wbeat_i.dmi[1])
        |=> arr_wr_o.en[1]
        && arr_wr_o.data[15:8] == ~$past(wbeat_i.dq[15:8]))
        else $error("inversion pattern not written inverted");

    a_train_store: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        s_wbeat(DMI_WFIFO) |=> !arr_wr_o.valid
        && lk_ff.fifo[$past(lk_ff.wptr)].dq == $past(wbeat_i.dq))
        else $error("training beat altered or written to array");

    a_train_return: assert property (@(posedge lk_clk_i)
        disable iff (lk_ff.rst_q)
        rreq_i.valid && rreq_i.kind == DMI_RFIFO && any_en
        |=> dmi_oe_n_o == '0
        && dmi_o == $past(lk_ff.fifo[lk_ff.rptr].dmi))
        else $error("training pattern not returned on pin");

endmodule : dmi_mask_inv_top

// ---- dmi_host_model.sv ----
// Purpose: host model driving write and read beats on the link
// Assumes: beats change on the falling link edge, held over one rise
// Notes: released lines show the inverted last value, never a copy
`timescale 1ns/1ps
module dmi_host_model
    import dmi_pkg::*;
(
    // link clock
    input wire logic lk_clk_i,
    // beats toward the device
    output dmi_wbeat_s wbeat_o,
    output dmi_rreq_s rreq_o
);
    // pair is differential from the command's own edge, well inside on delay
    localparam int write_strobe_on_delay = 8;
    localparam int write_strobe_off_delay = 36;
    logic strobe_t = 1'b0;
    logic strobe_c = 1'b1;
    int off_cnt = 0;

    // beats are never held back for the strobe pair
    always @(posedge lk_clk_i) begin
        if (wbeat_o.valid && wbeat_o.kind != DMI_WFIFO) begin
            strobe_t <= 1'b1;
            strobe_c <= 1'b0;
            off_cnt <= write_strobe_off_delay;
        end else if (off_cnt > 0) begin
            strobe_t <= ~strobe_t;
            strobe_c <= strobe_t;
            off_cnt <= off_cnt - 1;
        end else begin
            strobe_t <= 1'b0;
            strobe_c <= 1'b1;
        end
    end

    initial begin
        wbeat_o = '0;
        rreq_o = '0;
    end

    task automatic wr(input dmi_wkind_e k, input logic [15:0] dq,
                      input logic [1:0] pin);
        @(negedge lk_clk_i);
        wbeat_o <= '{1'b1, k, dq, pin};
        @(negedge lk_clk_i);
        wbeat_o <= '{1'b0, DMI_WR, ~dq, ~pin};
    endtask : wr

    task automatic rd(input dmi_rkind_e k, input logic [15:0] d);
        @(negedge lk_clk_i);
        rreq_o <= '{1'b1, k, d};
        @(negedge lk_clk_i);
        rreq_o <= '{1'b0, DMI_RD, ~d};
    endtask : rd
endmodule : dmi_host_model

// ---- tb_top.sv ----
// Purpose: self-checking bench for the mask/inversion byte lanes
// Assumes: mode bits settle within eight core cycles
// Notes: answers are awaited for at most three link cycles
`timescale 1ns/1ps
module tb_top;
    import dmi_pkg::*;
    logic clk_i = 1'b0;
    logic lk_clk = 1'b0;
    logic rst_i = 1'b1;
    logic dm_dis = 1'b1;
    logic wr_inv = 1'b0;
    logic rd_inv = 1'b0;
    logic illegal;
    dmi_wbeat_s wbeat;
    dmi_rreq_s rreq;
    dmi_arrw_s arr_wr;
    logic rx_en;
    logic [15:0] dq_o;
    logic dq_oe_n;
    logic [1:0] dmi_o;
    logic [1:0] dmi_oe_n;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    int ill_seen = 0;

    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        #1.3;
        forever #3 lk_clk = ~lk_clk;
    end

    dmi_host_model host (.lk_clk_i(lk_clk), .wbeat_o(wbeat), .rreq_o(rreq));
    dmi_mask_inv_top dut (.clk_i(clk_i), .rst_i(rst_i),
        .dm_disable_i(dm_dis), .wr_inv_en_i(wr_inv), .rd_inv_en_i(rd_inv),
        .illegal_cmd_o(illegal), .lk_clk_i(lk_clk), .wbeat_i(wbeat),
        .rreq_i(rreq), .arr_wr_o(arr_wr), .dmi_rx_en_o(rx_en),
        .dq_o(dq_o), .dq_oe_n_o(dq_oe_n), .dmi_o(dmi_o),
        .dmi_oe_n_o(dmi_oe_n));

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // the cdc needs a few cycles before mode bits reach the lanes
    task automatic cfg(input logic d, input logic w, input logic r);
        @(negedge clk_i);
        dm_dis = d;
        wr_inv = w;
        rd_inv = r;
        repeat (8) @(negedge clk_i);
    endtask : cfg

    task automatic do_wr(input dmi_wkind_e k, input logic [15:0] dq,
        input logic [1:0] pin, input logic ev, input logic [15:0] ed,
        input logic [1:0] een);
        logic [15:0] m;
        logic diff;
        m = {{8{een[1]}}, {8{een[0]}}};
        host.wr(k, dq, pin);
        for (int i = 0; i < 3; i++) begin
            if (arr_wr.valid === 1'b1) break;
            @(negedge lk_clk);
        end
        chk("arr valid", {15'h0, ev}, {15'h0, arr_wr.valid});
        if (ev) begin
            chk("arr en", {14'h0, een}, {14'h0, arr_wr.en});
            chk("arr data", ed & m, arr_wr.data & m);
        end
        diff = host.strobe_t ^ host.strobe_c;
        if (k != DMI_WFIFO) chk("strobe", 16'h1, {15'h0, diff});
    endtask : do_wr

    task automatic do_rd(input dmi_rkind_e k, input logic [15:0] d,
        input logic [15:0] edq, input logic [1:0] edmi,
        input logic [1:0] eoe);
        host.rd(k, d);
        for (int i = 0; i < 3; i++) begin
            if (dq_oe_n === 1'b0) break;
            @(negedge lk_clk);
        end
        chk("dq out", edq, dq_o);
        chk("dq oe", 16'h0, {15'h0, dq_oe_n});
        chk("pin oe", {14'h0, eoe}, {14'h0, dmi_oe_n});
        if (eoe == 2'h0) chk("pin out", {14'h0, edmi}, {14'h0, dmi_o});
        // drive lasts one link cycle only
        @(negedge lk_clk);
        chk("dq oe idle", 16'h1, {15'h0, dq_oe_n});
    endtask : do_rd

    task automatic t_all_off;
        cfg(1'b1, 1'b0, 1'b0);
        chk("rx en", 16'h0, {15'h0, rx_en});
        do_wr(DMI_WR, 16'h00ff, 2'h3, 1'b1, 16'h00ff, 2'h3);
        do_rd(DMI_RD, 16'h00ff, 16'h00ff, 2'h0, 2'h3);
    endtask : t_all_off

    task automatic t_wr_inv;
        cfg(1'b0, 1'b1, 1'b0);
        do_wr(DMI_WR, 16'ha50f, 2'h1, 1'b1, 16'ha5f0, 2'h3);
        do_wr(DMI_WR, 16'ha50f, 2'h2, 1'b1, 16'h5a0f, 2'h3);
        do_rd(DMI_RD, 16'h00ff, 16'h00ff, 2'h0, 2'h3);
    endtask : t_wr_inv

    task automatic t_rd_inv;
        cfg(1'b0, 1'b0, 1'b1);
        do_rd(DMI_RD, 16'h0f1f, 16'h0fe0, 2'h1, 2'h0);
        do_rd(DMI_RD, 16'hf010, 16'hf010, 2'h0, 2'h0);
        do_rd(DMI_RD, 16'hf800, 16'h0700, 2'h2, 2'h0);
    endtask : t_rd_inv

    task automatic t_mask_only;
        cfg(1'b0, 1'b0, 1'b0);
        chk("rx en", 16'h1, {15'h0, rx_en});
        do_wr(DMI_MWR, 16'h1234, 2'h1, 1'b1, 16'h1234, 2'h2);
        do_wr(DMI_MWR, 16'hffff, 2'h2, 1'b1, 16'hffff, 2'h1);
        do_wr(DMI_WR, 16'h1234, 2'h0, 1'b1, 16'h1234, 2'h3);
    endtask : t_mask_only

    task automatic t_mask_inv;
        cfg(1'b0, 1'b1, 1'b0);
        do_wr(DMI_MWR, 16'hfc03, 2'h0, 1'b1, 16'h0003, 2'h1);
        // five ones up top masks, four do not even with six in all
        do_wr(DMI_MWR, 16'h7c3f, 2'h0, 1'b1, 16'h003f, 2'h1);
        do_wr(DMI_MWR, 16'hfc03, 2'h2, 1'b1, 16'h0303, 2'h3);
        do_wr(DMI_MWR, 16'h03fc, 2'h0, 1'b1, 16'h0300, 2'h2);
    endtask : t_mask_inv

    task automatic t_illegal;
        int seen;
        seen = ill_seen;
        cfg(1'b1, 1'b0, 1'b0);
        do_wr(DMI_MWR, 16'h0f0f, 2'h0, 1'b0, 16'h0, 2'h0);
        repeat (12) @(negedge clk_i);
        seen = ill_seen - seen;
        chk("illegal pulses", 16'h1, seen[15:0]);
    endtask : t_illegal

    task automatic t_train;
        cfg(1'b0, 1'b1, 1'b1);
        do_wr(DMI_WFIFO, 16'habcd, 2'h2, 1'b0, 16'h0, 2'h0);
        do_rd(DMI_RFIFO, 16'h0000, 16'habcd, 2'h2, 2'h0);
    endtask : t_train

    // pulse may come and go while a write task still waits, so count here
    always @(negedge clk_i) begin
        if (illegal === 1'b1) ill_seen++;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        t_all_off();
        t_wr_inv();
        t_rd_inv();
        t_mask_only();
        t_mask_inv();
        t_illegal();
        t_train();
        complete_run();
    end
endmodule : tb_top
